// File: core/arsr_regs.sv
// ADC result, status and diagnostic register bank
`timescale 1ns/100ps
`include "arsr_defs.svh"
module arsr_regs #(
  parameter int CH_W = 3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  output logic             regRdValid,
  // Converter side
  input  wire logic        convDone,
  input  wire logic [23:0] convResult,
  input  wire logic [CH_W-1:0] convChannel,
  input  wire logic        convRailNear,
  input  wire logic        convOverPos,
  input  wire logic        convOverNeg,
  input  wire logic        porEvent,
  input  wire logic        scanUpdatePending,
  // Configuration
  input  wire logic        readyReleaseAfterCheck,
  input  wire logic        crcAutoResetDisable,
  // Outputs
  output arsr_pkg::arsr_cal_t calModeActive,
  output logic             resultReadyN
);

  initial begin
    if (CH_W < 1 || CH_W > 3) begin
      $error("arsr_regs channel width must be 1 to 3");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic wrLimitHigh;
  logic wrLimitLow;
  logic wrCal;
  logic wrCheck;
  logic rdFlags;
  logic rdResult;
  logic rdLow;
  logic rdCheck;

  assign wrLimitHigh = regWr && (regAddr == `ARSR_OFS_LIMIT_HIGH);
  assign wrLimitLow  = regWr && (regAddr == `ARSR_OFS_LIMIT_LOW);
  assign wrCal       = regWr && (regAddr == `ARSR_OFS_CAL_MODE);
  assign wrCheck     = regWr && (regAddr == `ARSR_OFS_LINK_CHECK);
  assign rdFlags     = regRd && (regAddr == `ARSR_OFS_DIAG_FLAGS);
  assign rdLow       = regRd && (regAddr == `ARSR_OFS_RESULT_LOW);
  assign rdCheck     = regRd && (regAddr == `ARSR_OFS_LINK_CHECK);
  assign rdResult    = regRd && (regAddr >= `ARSR_OFS_RESULT_HIGH) && (regAddr <= `ARSR_OFS_RESULT_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // Threshold and calibration mode

  logic [15:0]         limit_r;
  logic [15:0]         limit_nxt;
  arsr_pkg::arsr_cal_t calMode_r;
  arsr_pkg::arsr_cal_t calMode_nxt;

  always_comb begin
    limit_nxt   = limit_r;
    calMode_nxt = calMode_r;
    if (wrLimitHigh) begin
      limit_nxt[15:8] = regWdata;
    end
    if (wrLimitLow) begin
      limit_nxt[7:0] = regWdata;
    end
    if (convDone && calMode_r != `ARSR_CAL_NORMAL) begin
      calMode_nxt = `ARSR_CAL_NORMAL;
    end
    if (wrCal && regWdata[1:0] != `ARSR_CAL_RESERVED) begin
      calMode_nxt = regWdata[1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      limit_r   <= {`ARSR_BYTE_RESET, `ARSR_BYTE_RESET};
      calMode_r <= `ARSR_CAL_NORMAL;
    end else begin
      limit_r   <= limit_nxt;
      calMode_r <= calMode_nxt;
    end
  end

  assign calModeActive = calMode_r;

  ////////////////////////////////////////////////////////////////////////////
  // Result capture and diagnostic flags

  logic [23:0]         result_r;
  logic [23:0]         result_nxt;
  logic [23:0]         absResult;
  logic                short_r;
  logic                short_nxt;
  logic                rail_r;
  logic                rail_nxt;
  logic                por_r;
  logic                por_nxt;
  arsr_pkg::arsr_ovf_t ovf_r;
  arsr_pkg::arsr_ovf_t ovf_nxt;
  logic [CH_W-1:0]     chan_r;
  logic [CH_W-1:0]     chan_nxt;

  assign absResult = convResult[23] ? (~convResult + 24'h000001) : convResult;

  always_comb begin
    result_nxt = result_r;
    short_nxt  = short_r;
    ovf_nxt    = ovf_r;
    chan_nxt   = chan_r;
    rail_nxt   = convRailNear;
    por_nxt    = rdFlags ? 1'b0 : por_r;
    if (porEvent) begin
      por_nxt = 1'b1;
    end
    if (convDone) begin
      result_nxt = convResult;
      chan_nxt   = convChannel;
      short_nxt  = absResult <= {8'h00, limit_r};
      if (convOverPos) begin
        ovf_nxt = `ARSR_OVF_POSITIVE;
      end else if (convOverNeg) begin
        ovf_nxt = `ARSR_OVF_NEGATIVE;
      end else if (convResult == `ARSR_FULL_POS || convResult == `ARSR_FULL_NEG) begin
        ovf_nxt = `ARSR_OVF_CLAMPED;
      end else begin
        ovf_nxt = `ARSR_OVF_NORMAL;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= 24'h000000;
      short_r  <= 1'b0;
      rail_r   <= 1'b0;
      por_r    <= 1'b1;
      ovf_r    <= `ARSR_OVF_NORMAL;
      chan_r   <= '0;
    end else begin
      result_r <= result_nxt;
      short_r  <= short_nxt;
      rail_r   <= rail_nxt;
      por_r    <= por_nxt;
      ovf_r    <= ovf_nxt;
      chan_r   <= chan_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // New-data tracking and ready output

  arsr_pkg::arsr_ready_t rdy_r;
  arsr_pkg::arsr_ready_t rdy_nxt;
  logic                  dataNew_r;
  logic                  dataNew_nxt;
  logic                  stale_r;
  logic                  stale_nxt;
  logic                  readyN_r;
  logic                  releaseNow;

  always_comb begin
    rdy_nxt     = rdy_r;
    dataNew_nxt = rdLow ? 1'b0 : dataNew_r;
    stale_nxt   = stale_r;
    if (rdResult) begin
      stale_nxt = ~dataNew_r;
    end
    if (convDone) begin
      dataNew_nxt = 1'b1;
      rdy_nxt     = arsr_pkg::RDY_ASSERTED;
    end else begin
      // release after low or check byte
      unique case (rdy_r)
        arsr_pkg::RDY_IDLE: rdy_nxt = arsr_pkg::RDY_IDLE;
        arsr_pkg::RDY_ASSERTED: begin
          if (rdLow) begin
            rdy_nxt = readyReleaseAfterCheck ? arsr_pkg::RDY_WAIT_CHECK : arsr_pkg::RDY_IDLE;
          end
        end
        arsr_pkg::RDY_WAIT_CHECK: begin
          if (rdCheck) begin
            rdy_nxt = arsr_pkg::RDY_IDLE;
          end
        end
      endcase
    end
  end

  assign releaseNow = (rdy_r != arsr_pkg::RDY_IDLE) && (rdy_nxt == arsr_pkg::RDY_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_r     <= arsr_pkg::RDY_IDLE;
      dataNew_r <= 1'b0;
      stale_r   <= 1'b0;
      readyN_r  <= 1'b1;
    end else begin
      rdy_r     <= rdy_nxt;
      dataNew_r <= dataNew_nxt;
      stale_r   <= stale_nxt;
      readyN_r  <= (rdy_nxt == arsr_pkg::RDY_IDLE);
    end
  end

  assign resultReadyN = readyN_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link CRC and read-back

  logic       crcClear;
  logic       crcFeed;
  logic [7:0] crcFeedByte;
  logic [7:0] crcValue;
  logic [7:0] rdMux;
  logic [7:0] rdata_r;
  logic       rdValid_r;

  assign crcClear    = wrCheck || (releaseNow && !crcAutoResetDisable);
  assign crcFeed     = regWr || (regRd && !rdCheck);
  assign crcFeedByte = regWr ? regWdata : rdMux;

  arsr_crc #(
    .WIDTH (8),
    .POLY  (`ARSR_CRC_POLY),
    .INIT  (`ARSR_CRC_INIT)
  ) u_crc (
    .clk       (clk),
    .rst       (rst),
    .clear     (crcClear),
    .byteValid (crcFeed),
    .byteIn    (crcFeedByte),
    .crcValue  (crcValue)
  );

  always_comb begin
    rdMux = `ARSR_UNMAPPED_READ;
    unique case (regAddr)
      `ARSR_OFS_LIMIT_HIGH:  rdMux = limit_r[15:8];
      `ARSR_OFS_LIMIT_LOW:   rdMux = limit_r[7:0];
      `ARSR_OFS_CAL_MODE:    rdMux = {6'h00, calMode_r};
      `ARSR_OFS_READY_CODE:  rdMux = dataNew_r ? `ARSR_READY_NEW : `ARSR_READY_NONE;
      `ARSR_OFS_DIAG_FLAGS:  rdMux = {short_r, rail_r, por_r, ovf_r, 3'(chan_r)};
      `ARSR_OFS_RESULT_HIGH: rdMux = result_r[23:16];
      `ARSR_OFS_RESULT_MID:  rdMux = result_r[15:8];
      `ARSR_OFS_RESULT_LOW:  rdMux = result_r[7:0];
      `ARSR_OFS_LINK_CHECK:  rdMux = crcValue;
      `ARSR_OFS_SEQ_STATUS:  rdMux = {6'h00, scanUpdatePending, stale_nxt};
      default:               rdMux = `ARSR_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r   <= `ARSR_UNMAPPED_READ;
      rdValid_r <= 1'b0;
    end else begin
      rdata_r   <= regRd ? rdMux : rdata_r;
      rdValid_r <= regRd;
    end
  end

  assign regRdata   = rdata_r;
  assign regRdValid = rdValid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_low_read;
    rdLow && rdy_r == arsr_pkg::RDY_ASSERTED && !convDone;
  endsequence

  sequence s_check_read;
    rdCheck && rdy_r == arsr_pkg::RDY_WAIT_CHECK && !convDone;
  endsequence

  a_cal_one_conv: assert property (convDone && calMode_r != 2'h0 && !wrCal |=> calMode_r == 2'h0)
    else $error("calibration mode outlived one conversion");

  a_cal_reserved: assert property (wrCal && regWdata[1:0] == 2'h3 && !convDone |=> $stable(calMode_r))
    else $error("reserved calibration code accepted");

  a_ready_code: assert property (regRd && regAddr == 8'h18
      |=> regRdValid && regRdata == ($past(dataNew_r) ? 8'h00 : 8'hFF))
    else $error("ready code wrong");

  a_ready_low: assert property ((!readyReleaseAfterCheck) and s_low_read |=> resultReadyN)
    else $error("ready not released after low byte");
  a_ready_check: assert property (s_check_read |=> resultReadyN)
    else $error("ready not released after check byte");
  a_ready_hold: assert property (readyReleaseAfterCheck and s_low_read |=> !resultReadyN)
    else $error("ready released before check byte");

  a_por_clear: assert property (rdFlags && !porEvent |=> !por_r ##1 (por_r == $past(porEvent)))
    else $error("power-on flag not cleared by read");

  a_stale_read: assert property (rdResult && !dataNew_r |=> stale_r)
    else $error("stale result read not flagged");

  a_crc_write: assert property (wrCheck |=> crcValue == 8'h00)
    else $error("CRC not reset by write");

  a_ovf_pos: assert property (convDone && convOverPos |=> ovf_r == 2'h2 && chan_r == $past(convChannel))
    else $error("positive overrange code wrong");

  a_short_flag: assert property (convDone |=> short_r == ($past(absResult) <= {8'h00, $past(limit_r)}))
    else $error("short flag wrong");

endmodule

// File: core/arsr_defs.svh
// Constants for the ADC result and status register bank
`ifndef ARSR_DEFS_SVH
`define ARSR_DEFS_SVH

`define ARSR_OFS_LIMIT_HIGH   8'h14
`define ARSR_OFS_LIMIT_LOW    8'h15
`define ARSR_OFS_CAL_MODE     8'h17
`define ARSR_OFS_READY_CODE   8'h18
`define ARSR_OFS_DIAG_FLAGS   8'h19
`define ARSR_OFS_RESULT_HIGH  8'h1A
`define ARSR_OFS_RESULT_MID   8'h1B
`define ARSR_OFS_RESULT_LOW   8'h1C
`define ARSR_OFS_LINK_CHECK   8'h1D
`define ARSR_OFS_SEQ_STATUS   8'h1E

`define ARSR_BIT_SHORT        7
`define ARSR_BIT_RAIL         6
`define ARSR_BIT_POR          5
`define ARSR_BIT_STALE        0
`define ARSR_BIT_SCAN_PEND    1

`define ARSR_CAL_NORMAL       2'h0
`define ARSR_CAL_OFFSET       2'h1
`define ARSR_CAL_GAIN         2'h2
`define ARSR_CAL_RESERVED     2'h3

`define ARSR_OVF_NORMAL       2'h0
`define ARSR_OVF_CLAMPED      2'h1
`define ARSR_OVF_POSITIVE     2'h2
`define ARSR_OVF_NEGATIVE     2'h3

`define ARSR_FULL_POS         24'h7FFFFF
`define ARSR_FULL_NEG         24'h800000

`define ARSR_READY_NEW        8'h00
`define ARSR_READY_NONE       8'hFF
`define ARSR_BYTE_RESET       8'h00
`define ARSR_UNMAPPED_READ    8'h00

`define ARSR_CRC_POLY         8'h07
`define ARSR_CRC_INIT         8'h00

`define ARSR_CLK_NS           40
`define ARSR_REPEAT_READ_NS   72000
`define ARSR_REPEAT_READ_CYC  ((`ARSR_REPEAT_READ_NS + `ARSR_CLK_NS - 1) / `ARSR_CLK_NS)

`endif

// File: core/arsr_pkg.sv
// Types shared by the ADC result and status register bank
package arsr_pkg;

  typedef logic [1:0] arsr_cal_t;
  typedef logic [1:0] arsr_ovf_t;
  typedef logic [7:0] arsr_byte_t;

  typedef enum logic [1:0] {
    RDY_IDLE,
    RDY_ASSERTED,
    RDY_WAIT_CHECK
  } arsr_ready_t;

endpackage

// File: core/arsr_crc.sv
// Running CRC over bytes moved on the register port, other than link-check reads and writes and a low-byte read that releases ready with auto-reset on
`timescale 1ns/100ps
`include "arsr_defs.svh"
module arsr_crc #(
  parameter int         WIDTH = 8,
  parameter logic [7:0] POLY  = `ARSR_CRC_POLY,
  parameter logic [7:0] INIT  = `ARSR_CRC_INIT
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       clear,
  input  wire logic       byteValid,
  input  wire logic [7:0] byteIn,
  // Result
  output logic      [7:0] crcValue
);

  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic [7:0] step [0:8];

  initial begin
    if (WIDTH != 8) begin
      $error("arsr_crc serves only an 8-bit CRC");
    end
  end

  assign step[0] = crc_r ^ byteIn;

  // One bit of division per stage, MSB first
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign step[i+1] = step[i][7] ? ((step[i] << 1) ^ POLY) : (step[i] << 1);
  end

  always_comb begin
    crc_nxt = crc_r;
    if (clear) begin
      crc_nxt = INIT;
    end else if (byteValid) begin
      crc_nxt = step[8];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_r <= INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crcValue = crc_r;

endmodule

// File: verification/arsr_host.sv
// Host model driving the register port
`timescale 1ns/100ps
module arsr_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] regAddr,
  output logic            regWr,
  output logic            regRd,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRdValid
);
  realtime lastRes = -100000.0;
  initial begin
    regAddr = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regWdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // never sends calibration code 3; callers keep it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 regAddr = a;
    regWdata = v;
    regWr = 1'b1;
    @(posedge clk);
    #1 regWr = 1'b0;
    regAddr = ~a;
    regWdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    if (a >= 8'h1A && a <= 8'h1C) begin
      while ($realtime - lastRes < 72000.0) @(posedge clk);
      lastRes = $realtime;
    end
    @(posedge clk);
    #1 regAddr = a;
    regRd = 1'b1;
    @(posedge clk);
    #1 regRd = 1'b0;
    regAddr = ~a;
    v = regRdValid ? regRdata : 8'hXX;
  endtask
endmodule

// File: verification/arsr_regs_tb.sv
// Self-checking bench for the result and status registers
`timescale 1ns/100ps
module arsr_regs_tb;
  logic        clk, rst, regWr, regRd, regRdValid, convDone;
  logic        convRailNear, convOverPos, convOverNeg, porEvent;
  logic        scanUpdatePending, readyReleaseAfterCheck;
  logic        crcAutoResetDisable, resultReadyN;
  logic [7:0]  regAddr, regWdata, regRdata, d;
  logic [23:0] convResult;
  logic [2:0]  convChannel;
  logic [7:0]  c;
  arsr_pkg::arsr_cal_t calModeActive;
  int          miscompares = 0;
  int          checked = 0;

  arsr_regs #(.CH_W(3)) dut_u (.clk, .rst, .regAddr, .regWr, .regRd,
    .regWdata, .regRdata, .regRdValid, .convDone, .convResult,
    .convChannel, .convRailNear, .convOverPos, .convOverNeg, .porEvent,
    .scanUpdatePending, .readyReleaseAfterCheck, .crcAutoResetDisable,
    .calModeActive, .resultReadyN);
  arsr_host host_u (.clk, .regAddr, .regWr, .regRd, .regWdata,
    .regRdata, .regRdValid);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic conv(input logic [23:0] r, input logic [2:0] ch,
                      input logic p, input logic n);
    @(posedge clk);
    #1 convDone = 1'b1;
    convResult = r;
    convChannel = ch;
    convOverPos = p;
    convOverNeg = n;
    @(posedge clk);
    #1 convDone = 1'b0;
    convResult = ~r;
    convOverPos = 1'b0;
    convOverNeg = 1'b0;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] s, input logic [7:0] b);
    logic [7:0] x;
    x = s ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(calModeActive, 2'h0);
    chk(resultReadyN, 1'h1);
    rdc(8'h18, 8'hFF);
    rdc(8'h19, 8'h20);
    rdc(8'h19, 8'h00);
    rdc(8'h16, 8'h00);
  endtask
  task automatic t_thr;
    host_u.wr(8'h14, 8'hA5);
    host_u.wr(8'h15, 8'h3C);
    rdc(8'h14, 8'hA5);
    rdc(8'h15, 8'h3C);
    host_u.wr(8'h14, 8'h00);
    host_u.wr(8'h15, 8'h10);
  endtask
  task automatic t_result;
    conv(24'h123456, 3'h5, 1'b0, 1'b0);
    chk(resultReadyN, 1'h0);
    rdc(8'h18, 8'h00);
    rdc(8'h19, 8'h05);
    rdc(8'h1A, 8'h12);
    rdc(8'h1B, 8'h34);
    rdc(8'h1C, 8'h56);
    chk(resultReadyN, 1'h1);
    rdc(8'h1E, 8'h00);
    rdc(8'h18, 8'hFF);
    rdc(8'h1C, 8'h56);
    rdc(8'h1E, 8'h01);
  endtask
  task automatic t_flags;
    logic [23:0] rv[6];
    logic [7:0]  ev[6];
    rv = '{24'h7FFFFF, 24'h800000, 24'h000100, 24'h000100, 24'h000011, 24'h000010};
    ev = '{8'h08, 8'h08, 8'h10, 8'h18, 8'h00, 8'h80};
    convRailNear = 1'b1;
    conv(24'hFFFFFB, 3'h2, 1'b0, 1'b0);
    rdc(8'h19, 8'hC2);
    convRailNear = 1'b0;
    porEvent = 1'b1;
    @(posedge clk);
    #1 porEvent = 1'b0;
    rdc(8'h19, 8'hA2);
    for (int i = 0; i < 6; i++) begin
      conv(rv[i], i[2:0], i == 2, i == 3);
      rdc(8'h19, ev[i] | 8'(i));
    end
  endtask
  task automatic t_cal;
    host_u.wr(8'h17, 8'h01);
    chk(calModeActive, 2'h1);
    rdc(8'h17, 8'h01);
    conv(24'h000000, 3'h0, 1'b0, 1'b0);
    chk(calModeActive, 2'h0);
    host_u.wr(8'h17, 8'hFE);
    rdc(8'h17, 8'h02);
    conv(24'h000000, 3'h0, 1'b0, 1'b0);
    rdc(8'h17, 8'h00);
  endtask
  task automatic t_crc;
    host_u.wr(8'h1D, 8'h77);
    rdc(8'h1D, 8'h00);
    host_u.wr(8'h14, 8'h5A);
    rdc(8'h14, 8'h5A);
    rdc(8'h1D, crc8(crc8(8'h00, 8'h5A), 8'h5A));
  endtask
  task automatic t_after;
    readyReleaseAfterCheck = 1'b1;
    for (int i = 0; i < 2; i++) begin
      crcAutoResetDisable = i[0];
      host_u.wr(8'h1D, 8'h00);
      conv(24'h00ABCD, 3'h1, 1'b0, 1'b0);
      rdc(8'h1C, 8'hCD);
      chk(resultReadyN, 1'h0);
      c = crc8(8'h00, 8'hCD);
      rdc(8'h1D, c);
      chk(resultReadyN, 1'h1);
      rdc(8'h1D, i[0] ? c : 8'h00);
    end
    readyReleaseAfterCheck = 1'b0;
    crcAutoResetDisable = 1'b0;
  endtask
  task automatic t_scan;
    scanUpdatePending = 1'b1;
    rdc(8'h1E, 8'h02);
    scanUpdatePending = 1'b0;
    rdc(8'h1E, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {convDone, convRailNear, convOverPos, convOverNeg, porEvent} = 5'h00;
    {scanUpdatePending, readyReleaseAfterCheck, crcAutoResetDisable} = 3'h0;
    convResult = 24'h000000;
    convChannel = 3'h0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_thr();
    t_result();
    t_flags();
    t_cal();
    t_crc();
    t_after();
    t_scan();
    final_report();
  end
  initial begin
    #3900000;
    miscompares++;
    final_report();
  end
endmodule
